// ---- verilog/bfie_params.svh ----
`ifndef BFIE_PARAMS_SVH
`define BFIE_PARAMS_SVH
`define BFIE_DATA_W 8
`define BFIE_REG_COUNT 32
`define BFIE_REG_IDX_W 5
`define BFIE_IO_ADDR_W 6
`define BFIE_BIT_IDX_W 3
`define BFIE_PROG_W 16
`define BFIE_ZPAIR_W 16
`define BFIE_R0_IDX 5'h00
`define BFIE_ZLO_IDX 5'h1E
`define BFIE_FLAG_C 3'h0
`define BFIE_FLAG_Z 3'h1
`define BFIE_FLAG_N 3'h2
`define BFIE_FLAG_V 3'h3
`define BFIE_FLAG_S 3'h4
`define BFIE_FLAG_H 3'h5
`define BFIE_FLAG_T 3'h6
`define BFIE_FLAG_I 3'h7
`define BFIE_STATUS_RESET 8'h00
`define BFIE_BIT_ONE 8'h01
`define BFIE_BYTE_ZERO 8'h00
`endif

// ---- verilog/bfie_pkg.sv ----
`default_nettype none
`include "bfie_params.svh"
package bfie_pkg;
  typedef enum logic [4:0] {
    BFIE_OP_NOP = 5'h00,
    BFIE_OP_MOVE = 5'h01,
    BFIE_OP_LOAD_IMM = 5'h02,
    BFIE_OP_IO_IN = 5'h03,
    BFIE_OP_IO_OUT = 5'h04,
    BFIE_OP_INDIRECT_FETCH = 5'h05,
    BFIE_OP_INDIRECT_WRITE = 5'h06,
    BFIE_OP_PROGRAM_MEMORY_FETCH = 5'h07,
    BFIE_OP_IO_BIT_SETTER = 5'h08,
    BFIE_OP_IO_BIT_CLEARER = 5'h09,
    BFIE_OP_ROTATE_LEFT_CARRY = 5'h0A,
    BFIE_OP_ROTATE_RIGHT_CARRY = 5'h0B,
    BFIE_OP_SHIFT_LEFT = 5'h0C,
    BFIE_OP_SHIFT_RIGHT = 5'h0D,
    BFIE_OP_SHIFT_RIGHT_SIGNED = 5'h0E,
    BFIE_OP_NIBBLE_SWAP = 5'h0F,
    BFIE_OP_REG_BIT_TO_TFLAG = 5'h10,
    BFIE_OP_TFLAG_TO_REG_BIT = 5'h11,
    BFIE_OP_FLAG_RAISE = 5'h12,
    BFIE_OP_FLAG_DROP = 5'h13,
    BFIE_OP_SLEEP = 5'h14,
    BFIE_OP_WATCHDOG_KICK = 5'h15
  } bfie_op_t;

  typedef enum logic [2:0] {
    BFIE_STATE_EXEC = 3'h1,
    BFIE_STATE_HOLD1 = 3'h2,
    BFIE_STATE_HOLD2 = 3'h4
  } bfie_state_t;

  typedef struct packed {
    bfie_state_t state;
    logic exValid;
    bfie_op_t exOp;
    logic [`BFIE_REG_IDX_W-1:0] exDst;
    logic [`BFIE_BIT_IDX_W-1:0] exBit;
    logic [`BFIE_DATA_W-1:0] exImm;
    logic [`BFIE_DATA_W-1:0] statusRegister;
    logic ready;
    logic ioRd;
    logic [`BFIE_IO_ADDR_W-1:0] ioRdAddr;
    logic ioWr;
    logic [`BFIE_IO_ADDR_W-1:0] ioWrAddr;
    logic [`BFIE_DATA_W-1:0] ioWrData;
    logic dataRd;
    logic dataWr;
    logic progRd;
    logic progHiByte;
    logic [`BFIE_DATA_W-1:0] progByte;
    logic sleepReq;
    logic wdtKick;
  } bfie_core_t;

  typedef struct packed {
    logic [`BFIE_DATA_W-1:0] rdA;
    logic [`BFIE_DATA_W-1:0] rdB;
    logic [`BFIE_ZPAIR_W-1:0] zPair;
  } bfie_rf_read_t;
endpackage : bfie_pkg
`default_nettype wire

// ---- verilog/bfie_reg_file.sv ----
`default_nettype none
`include "bfie_params.svh"
module bfie_reg_file #(
  parameter int DEPTH = `BFIE_REG_COUNT,
  parameter int AW = `BFIE_REG_IDX_W
) (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // write port
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [`BFIE_DATA_W-1:0] wdata,
  // read ports, data one cycle after address
  input wire logic [AW-1:0] raddrA,
  input wire logic [AW-1:0] raddrB,
  output logic [`BFIE_DATA_W-1:0] rdataA,
  output logic [`BFIE_DATA_W-1:0] rdataB,
  output logic [`BFIE_ZPAIR_W-1:0] zPair
);
  logic [`BFIE_DATA_W-1:0] mem [DEPTH];
  bfie_pkg::bfie_rf_read_t r;
  bfie_pkg::bfie_rf_read_t next_r;
  localparam logic [AW-1:0] ZLO = `BFIE_ZLO_IDX;
  localparam logic [AW-1:0] ZHI = ZLO + 1'b1;

  // write-first forwarding so a write and a read of one register agree
  function automatic logic [`BFIE_DATA_W-1:0] fwd(input logic [AW-1:0] a);
    fwd = (we && waddr == a) ? wdata : mem[a];
  endfunction : fwd

  always_comb begin
    next_r.rdA = fwd(raddrA);
    next_r.rdB = fwd(raddrB);
    next_r.zPair = {fwd(ZHI), fwd(ZLO)};
  end

  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign rdataA = r.rdA;
  assign rdataB = r.rdB;
  assign zPair = r.zPair;
endmodule : bfie_reg_file
`default_nettype wire

// ---- verilog/bfie_bit_unit.sv ----
`default_nettype none
`include "bfie_params.svh"
module bfie_bit_unit (
  // operation
  input wire bfie_pkg::bfie_op_t op,
  input wire logic [`BFIE_DATA_W-1:0] value,
  input wire logic carryIn,
  input wire logic tFlag,
  input wire logic [`BFIE_BIT_IDX_W-1:0] bitSel,
  // result and flags
  output logic [`BFIE_DATA_W-1:0] result,
  output logic cOut,
  output logic zOut,
  output logic nOut,
  output logic vOut,
  output logic sOut
);
  always_comb begin
    result = value;
    cOut = carryIn;
    case (op)
      bfie_pkg::BFIE_OP_ROTATE_LEFT_CARRY: begin
        result = {value[`BFIE_DATA_W-2:0], carryIn};
        cOut = value[`BFIE_DATA_W-1];
      end
      bfie_pkg::BFIE_OP_ROTATE_RIGHT_CARRY: begin
        result = {carryIn, value[`BFIE_DATA_W-1:1]};
        cOut = value[0];
      end
      bfie_pkg::BFIE_OP_SHIFT_LEFT: begin
        result = {value[`BFIE_DATA_W-2:0], 1'b0};
        cOut = value[`BFIE_DATA_W-1];
      end
      bfie_pkg::BFIE_OP_SHIFT_RIGHT: begin
        result = {1'b0, value[`BFIE_DATA_W-1:1]};
        cOut = value[0];
      end
      bfie_pkg::BFIE_OP_SHIFT_RIGHT_SIGNED: begin
        result = {value[`BFIE_DATA_W-1], value[`BFIE_DATA_W-1:1]};
        cOut = value[0];
      end
      bfie_pkg::BFIE_OP_NIBBLE_SWAP: begin
        result = {value[3:0], value[7:4]};
      end
      bfie_pkg::BFIE_OP_TFLAG_TO_REG_BIT: begin
        result[bitSel] = tFlag;
      end
      default: begin
        result = value;
      end
    endcase
  end

  assign zOut = (result == `BFIE_BYTE_ZERO);
  assign nOut = result[`BFIE_DATA_W-1];
  assign vOut = nOut ^ cOut;
  assign sOut = nOut ^ vOut;
endmodule : bfie_bit_unit
`default_nettype wire

// ---- verilog/bfie_exec.sv ----
// Notes on behaviour
// - copy register bit into T, one clock
// - write T into register bit, one clock
// - set/clear I/O bit, two clocks, flags kept
// - rotate left through carry, update Z C N V
// - rotate right through carry, update Z C N V
// - raise overflow flag alone, one clock
// - drop overflow flag alone, one clock
// - raise half-carry flag alone, one clock
// - drop half-carry flag alone, one clock
// - raise signed-test flag alone, one clock
// - drop signed-test flag alone, one clock
// - sleep: one clock, flags kept, request sleep
// - watchdog kick: one clock, flags kept, restart timer
//
// Local design decisions: strobed register access and the placing of the registers.
`default_nettype none
`include "bfie_params.svh"
module bfie_exec (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // instruction issue
  input wire logic instrValid,
  input wire bfie_pkg::bfie_op_t instrOp,
  input wire logic [`BFIE_REG_IDX_W-1:0] instrDst,
  input wire logic [`BFIE_REG_IDX_W-1:0] instrSrc,
  input wire logic [`BFIE_BIT_IDX_W-1:0] instrBit,
  input wire logic [`BFIE_DATA_W-1:0] instrImm,
  input wire logic [`BFIE_IO_ADDR_W-1:0] instrIo,
  output logic instrReady,
  // i/o register bus
  output logic ioRd,
  output logic [`BFIE_IO_ADDR_W-1:0] ioRdAddr,
  input wire logic [`BFIE_DATA_W-1:0] ioRdData,
  output logic ioWr,
  output logic [`BFIE_IO_ADDR_W-1:0] ioWrAddr,
  output logic [`BFIE_DATA_W-1:0] ioWrData,
  // data memory
  output logic dataRd,
  output logic dataWr,
  output logic [`BFIE_ZPAIR_W-1:0] dataAddr,
  output logic [`BFIE_DATA_W-1:0] dataWrData,
  input wire logic [`BFIE_DATA_W-1:0] dataRdData,
  // program memory
  output logic progRd,
  output logic [`BFIE_ZPAIR_W-2:0] progAddr,
  input wire logic [`BFIE_PROG_W-1:0] progRdData,
  // system
  output logic [`BFIE_DATA_W-1:0] statusRegister,
  output logic sleepReq,
  output logic wdtKick
);
  bfie_pkg::bfie_core_t s;
  bfie_pkg::bfie_core_t next_s;
  logic take;
  logic rfWe;
  logic [`BFIE_REG_IDX_W-1:0] rfWaddr;
  logic [`BFIE_DATA_W-1:0] rfWdata;
  logic [`BFIE_DATA_W-1:0] rdA;
  logic [`BFIE_DATA_W-1:0] rdB;
  logic [`BFIE_ZPAIR_W-1:0] zPair;
  logic [`BFIE_DATA_W-1:0] unitResult;
  logic unitC;
  logic unitZ;
  logic unitN;
  logic unitV;
  logic unitS;
  logic [`BFIE_DATA_W-1:0] bitMask;

  assign take = instrValid && s.ready;
  assign bitMask = `BFIE_BIT_ONE << s.exBit;

  bfie_reg_file bfie_reg_file_inst (
    .clk(clk),
    .resetn(resetn),
    .we(rfWe),
    .waddr(rfWaddr),
    .wdata(rfWdata),
    .raddrA(instrDst),
    .raddrB(instrSrc),
    .rdataA(rdA),
    .rdataB(rdB),
    .zPair(zPair)
  );

  bfie_bit_unit bfie_bit_unit_inst (
    .op(s.exOp),
    .value(rdA),
    .carryIn(s.statusRegister[`BFIE_FLAG_C]),
    .tFlag(s.statusRegister[`BFIE_FLAG_T]),
    .bitSel(s.exBit),
    .result(unitResult),
    .cOut(unitC),
    .zOut(unitZ),
    .nOut(unitN),
    .vOut(unitV),
    .sOut(unitS)
  );

  always_comb begin
    next_s = s;
    next_s.ioRd = 1'b0;
    next_s.ioWr = 1'b0;
    next_s.dataRd = 1'b0;
    next_s.dataWr = 1'b0;
    next_s.progRd = 1'b0;
    next_s.sleepReq = 1'b0;
    next_s.wdtKick = 1'b0;
    rfWe = 1'b0;
    rfWaddr = s.exDst;
    rfWdata = unitResult;
    unique case (s.state)
      bfie_pkg::BFIE_STATE_EXEC: begin
        next_s.exValid = 1'b0;
        if (s.exValid) begin
          case (s.exOp)
            bfie_pkg::BFIE_OP_MOVE: begin
              rfWe = 1'b1;
              rfWdata = rdB;
            end
            bfie_pkg::BFIE_OP_LOAD_IMM: begin
              rfWe = 1'b1;
              rfWdata = s.exImm;
            end
            bfie_pkg::BFIE_OP_IO_IN: begin
              rfWe = 1'b1;
              rfWdata = ioRdData;
            end
            bfie_pkg::BFIE_OP_IO_OUT: begin
              next_s.ioWr = 1'b1;
              next_s.ioWrAddr = s.ioRdAddr;
              next_s.ioWrData = rdB;
            end
            bfie_pkg::BFIE_OP_INDIRECT_FETCH,
            bfie_pkg::BFIE_OP_INDIRECT_WRITE: begin
              next_s.state = bfie_pkg::BFIE_STATE_HOLD1;
              next_s.ready = 1'b1;
            end
            bfie_pkg::BFIE_OP_PROGRAM_MEMORY_FETCH: begin
              next_s.state = bfie_pkg::BFIE_STATE_HOLD1;
              next_s.progHiByte = zPair[0];
            end
            bfie_pkg::BFIE_OP_IO_BIT_SETTER: begin
              next_s.ioWr = 1'b1;
              next_s.ioWrAddr = s.ioRdAddr;
              next_s.ioWrData = ioRdData | bitMask;
              next_s.state = bfie_pkg::BFIE_STATE_HOLD1;
              next_s.ready = 1'b1;
            end
            bfie_pkg::BFIE_OP_IO_BIT_CLEARER: begin
              next_s.ioWr = 1'b1;
              next_s.ioWrAddr = s.ioRdAddr;
              next_s.ioWrData = ioRdData & ~bitMask;
              next_s.state = bfie_pkg::BFIE_STATE_HOLD1;
              next_s.ready = 1'b1;
            end
            bfie_pkg::BFIE_OP_ROTATE_LEFT_CARRY,
            bfie_pkg::BFIE_OP_ROTATE_RIGHT_CARRY,
            bfie_pkg::BFIE_OP_SHIFT_LEFT,
            bfie_pkg::BFIE_OP_SHIFT_RIGHT,
            bfie_pkg::BFIE_OP_SHIFT_RIGHT_SIGNED: begin
              rfWe = 1'b1;
              next_s.statusRegister[`BFIE_FLAG_C] = unitC;
              next_s.statusRegister[`BFIE_FLAG_Z] = unitZ;
              next_s.statusRegister[`BFIE_FLAG_N] = unitN;
              next_s.statusRegister[`BFIE_FLAG_V] = unitV;
              next_s.statusRegister[`BFIE_FLAG_S] = unitS;
            end
            bfie_pkg::BFIE_OP_NIBBLE_SWAP,
            bfie_pkg::BFIE_OP_TFLAG_TO_REG_BIT: begin
              rfWe = 1'b1;
            end
            bfie_pkg::BFIE_OP_REG_BIT_TO_TFLAG: begin
              next_s.statusRegister[`BFIE_FLAG_T] = rdA[s.exBit];
            end
            bfie_pkg::BFIE_OP_FLAG_RAISE: begin
              next_s.statusRegister[s.exBit] = 1'b1;
            end
            bfie_pkg::BFIE_OP_FLAG_DROP: begin
              next_s.statusRegister[s.exBit] = 1'b0;
            end
            default: begin
              rfWe = 1'b0;
            end
          endcase
        end
      end
      bfie_pkg::BFIE_STATE_HOLD1: begin
        next_s.exValid = 1'b0;
        next_s.state = bfie_pkg::BFIE_STATE_EXEC;
        if (s.exOp == bfie_pkg::BFIE_OP_INDIRECT_FETCH) begin
          rfWe = 1'b1;
          rfWdata = dataRdData;
        end
        if (s.exOp == bfie_pkg::BFIE_OP_PROGRAM_MEMORY_FETCH) begin
          next_s.progByte = s.progHiByte ? progRdData[`BFIE_PROG_W-1:`BFIE_DATA_W] :
                            progRdData[`BFIE_DATA_W-1:0];
          next_s.state = bfie_pkg::BFIE_STATE_HOLD2;
          next_s.ready = 1'b1;
        end
      end
      bfie_pkg::BFIE_STATE_HOLD2: begin
        rfWe = 1'b1;
        rfWaddr = `BFIE_R0_IDX;
        rfWdata = s.progByte;
        next_s.exValid = 1'b0;
        next_s.state = bfie_pkg::BFIE_STATE_EXEC;
      end
    endcase
    if (take) begin
      next_s.state = bfie_pkg::BFIE_STATE_EXEC;
      next_s.exValid = 1'b1;
      next_s.exOp = instrOp;
      next_s.exDst = instrDst;
      next_s.exBit = instrBit;
      next_s.exImm = instrImm;
      next_s.ioRdAddr = instrIo;
      next_s.ready = !(instrOp inside {bfie_pkg::BFIE_OP_INDIRECT_FETCH,
                                       bfie_pkg::BFIE_OP_INDIRECT_WRITE,
                                       bfie_pkg::BFIE_OP_PROGRAM_MEMORY_FETCH,
                                       bfie_pkg::BFIE_OP_IO_BIT_SETTER,
                                       bfie_pkg::BFIE_OP_IO_BIT_CLEARER});
      next_s.ioRd = instrOp inside {bfie_pkg::BFIE_OP_IO_IN,
                                    bfie_pkg::BFIE_OP_IO_BIT_SETTER,
                                    bfie_pkg::BFIE_OP_IO_BIT_CLEARER};
      next_s.dataRd = (instrOp == bfie_pkg::BFIE_OP_INDIRECT_FETCH);
      next_s.dataWr = (instrOp == bfie_pkg::BFIE_OP_INDIRECT_WRITE);
      next_s.progRd = (instrOp == bfie_pkg::BFIE_OP_PROGRAM_MEMORY_FETCH);
      next_s.sleepReq = (instrOp == bfie_pkg::BFIE_OP_SLEEP);
      next_s.wdtKick = (instrOp == bfie_pkg::BFIE_OP_WATCHDOG_KICK);
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s <= '0;
      s.state <= bfie_pkg::BFIE_STATE_EXEC;
      s.ready <= 1'b1;
      s.statusRegister <= `BFIE_STATUS_RESET;
    end else begin
      s <= next_s;
    end
  end

  assign instrReady = s.ready;
  assign ioRd = s.ioRd;
  assign ioRdAddr = s.ioRdAddr;
  assign ioWr = s.ioWr;
  assign ioWrAddr = s.ioWrAddr;
  assign ioWrData = s.ioWrData;
  assign dataRd = s.dataRd;
  assign dataWr = s.dataWr;
  assign dataAddr = zPair;
  assign dataWrData = rdB;
  assign progRd = s.progRd;
  assign progAddr = zPair[`BFIE_ZPAIR_W-1:1];
  assign statusRegister = s.statusRegister;
  assign sleepReq = s.sleepReq;
  assign wdtKick = s.wdtKick;

  // checking helpers
  logic execNow;
  logic selBit;
  logic [`BFIE_DATA_W-1:0] tExpect;
  logic [`BFIE_DATA_W-1:0] raiseExpect;
  logic [`BFIE_DATA_W-1:0] dropExpect;
  assign execNow = s.exValid && (s.state == bfie_pkg::BFIE_STATE_EXEC);
  assign selBit = rdA[s.exBit];
  always_comb begin
    tExpect = s.statusRegister;
    tExpect[`BFIE_FLAG_T] = selBit;
  end
  assign raiseExpect = s.statusRegister | bitMask;
  assign dropExpect = s.statusRegister & ~bitMask;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  tflag_copy_a: assert property (
    execNow && s.exOp == bfie_pkg::BFIE_OP_REG_BIT_TO_TFLAG
    |=> statusRegister == $past(tExpect))
    else $error("T copy from register bit wrong");
  tflag_write_a: assert property (
    execNow && s.exOp == bfie_pkg::BFIE_OP_TFLAG_TO_REG_BIT
    |-> rfWe && rfWdata[s.exBit] == statusRegister[`BFIE_FLAG_T]
    ##1 statusRegister == $past(statusRegister))
    else $error("T write into register bit wrong");
  io_set_a: assert property (
    execNow && s.exOp == bfie_pkg::BFIE_OP_IO_BIT_SETTER && ioRd
    |=> ioWr && instrReady && ioWrData == ($past(ioRdData) | $past(bitMask))
    && statusRegister == $past(statusRegister))
    else $error("I/O bit set wrong");
  io_clear_a: assert property (
    execNow && s.exOp == bfie_pkg::BFIE_OP_IO_BIT_CLEARER && ioRd
    |=> ioWr && ioWrData == ($past(ioRdData) & ~$past(bitMask))
    && s.state == bfie_pkg::BFIE_STATE_HOLD1)
    else $error("I/O bit clear wrong");
  rotate_left_a: assert property (
    execNow && s.exOp == bfie_pkg::BFIE_OP_ROTATE_LEFT_CARRY
    |-> rfWe && rfWdata == {rdA[6:0], statusRegister[`BFIE_FLAG_C]}
    ##1 statusRegister[`BFIE_FLAG_C] == $past(rdA[7])
    && statusRegister[`BFIE_FLAG_Z] == ($past(rfWdata) == `BFIE_BYTE_ZERO))
    else $error("rotate left through carry wrong");
  rotate_right_a: assert property (
    execNow && s.exOp == bfie_pkg::BFIE_OP_ROTATE_RIGHT_CARRY
    |-> rfWe && rfWdata == {statusRegister[`BFIE_FLAG_C], rdA[7:1]}
    ##1 statusRegister[`BFIE_FLAG_C] == $past(rdA[0])
    && statusRegister[`BFIE_FLAG_N] == $past(statusRegister[`BFIE_FLAG_C]))
    else $error("rotate right through carry wrong");
  flag_raise_a: assert property (
    execNow && s.exOp == bfie_pkg::BFIE_OP_FLAG_RAISE
    |=> statusRegister == $past(raiseExpect) && instrReady)
    else $error("flag raise wrong");
  flag_drop_a: assert property (
    execNow && s.exOp == bfie_pkg::BFIE_OP_FLAG_DROP
    |=> statusRegister == $past(dropExpect) && instrReady)
    else $error("flag drop wrong");
  sleep_pulse_a: assert property (
    take && instrOp == bfie_pkg::BFIE_OP_SLEEP
    |=> sleepReq && instrReady ##1 !sleepReq && statusRegister == $past(statusRegister))
    else $error("sleep request wrong");
  wdt_kick_a: assert property (
    take && instrOp == bfie_pkg::BFIE_OP_WATCHDOG_KICK
    |=> wdtKick ##1 !wdtKick && statusRegister == $past(statusRegister))
    else $error("watchdog kick wrong");
  ind_fetch_a: assert property (
    take && instrOp == bfie_pkg::BFIE_OP_INDIRECT_FETCH
    |=> dataRd && !instrReady
    ##1 instrReady && rfWe && rfWdata == dataRdData && rfWaddr == $past(s.exDst))
    else $error("indirect fetch timing wrong");
  prog_fetch_a: assert property (
    take && instrOp == bfie_pkg::BFIE_OP_PROGRAM_MEMORY_FETCH
    |=> progRd && !instrReady ##1 !rfWe && !instrReady
    ##1 rfWe && instrReady && rfWaddr == `BFIE_R0_IDX)
    else $error("program fetch timing wrong");
  one_clock_a: assert property (
    execNow && s.exOp inside {bfie_pkg::BFIE_OP_MOVE, bfie_pkg::BFIE_OP_LOAD_IMM,
                              bfie_pkg::BFIE_OP_IO_IN}
    |-> rfWe && instrReady ##1 statusRegister == $past(statusRegister))
    else $error("single clock transfer wrong");

  rotate_c: cover property (execNow && s.exOp == bfie_pkg::BFIE_OP_ROTATE_LEFT_CARRY);
  prog_c: cover property (s.state == bfie_pkg::BFIE_STATE_HOLD2 ##1 execNow);
  io_b2b_c: cover property (ioWr && ioRd);
  t_c: cover property (execNow && s.exOp == bfie_pkg::BFIE_OP_REG_BIT_TO_TFLAG
                       ##1 execNow && s.exOp == bfie_pkg::BFIE_OP_TFLAG_TO_REG_BIT);
endmodule : bfie_exec
`default_nettype wire

// ---- verification/bfie_exec_bench.sv ----
`default_nettype none
`include "bfie_params.svh"
module bfie_exec_bench;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct packed {
    bfie_pkg::bfie_op_t op;
    logic [4:0] d;
    logic [4:0] s;
    logic [2:0] b;
    logic [7:0] k;
    logic [7:0] sr;
    logic [7:0] out;
  } bfie_row_t;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic instrValid = 1'b0;
  bfie_pkg::bfie_op_t instrOp = bfie_pkg::BFIE_OP_NOP;
  logic [4:0] instrDst = 5'h00;
  logic [4:0] instrSrc = 5'h00;
  logic [2:0] instrBit = 3'h0;
  logic [7:0] instrImm = 8'h00;
  logic [5:0] instrIo = 6'h00;
  logic [7:0] ioVal = 8'h00;
  logic [7:0] memVal = 8'h00;
  logic [15:0] progVal = 16'h0000;
  logic [7:0] dataRdData = 8'h00;
  logic [15:0] progRdData = 16'h0000;
  logic [7:0] ioRdData;
  logic instrReady, ioRd, ioWr, dataRd, dataWr, progRd, sleepReq, wdtKick;
  logic [5:0] ioRdAddr, ioWrAddr;
  logic [7:0] ioWrData, dataWrData, statusRegister;
  logic [15:0] dataAddr;
  logic [14:0] progAddr;
  logic s1IoRd, s1DataRd, s1DataWr, s1ProgRd, s1Ready, s1Sleep, s1Kick;
  logic s2IoWr, s2Ready, s2Sleep, s2Kick;
  logic [5:0] s1IoAddr, s2IoAddr;
  logic [7:0] s1DataWrData, s2IoData, s2Sr, expSr;
  logic [15:0] s1DataAddr;
  logic [14:0] s1ProgAddr;
  int n_errors = 0;
  int checked = 0;
  bfie_row_t rows [29] = '{
    '{bfie_pkg::BFIE_OP_LOAD_IMM, 5'h10, 5'h00, 3'h0, 8'h81, 8'h00, 8'h00},
    '{bfie_pkg::BFIE_OP_IO_OUT, 5'h00, 5'h10, 3'h0, 8'h00, 8'h00, 8'h81},
    '{bfie_pkg::BFIE_OP_FLAG_RAISE, 5'h00, 5'h00, 3'h0, 8'h00, 8'h01, 8'h00},
    '{bfie_pkg::BFIE_OP_ROTATE_LEFT_CARRY, 5'h10, 5'h00, 3'h0, 8'h00, 8'h19, 8'h00},
    '{bfie_pkg::BFIE_OP_IO_OUT, 5'h00, 5'h10, 3'h0, 8'h00, 8'h19, 8'h03},
    '{bfie_pkg::BFIE_OP_ROTATE_RIGHT_CARRY, 5'h10, 5'h00, 3'h0, 8'h00, 8'h15, 8'h00},
    '{bfie_pkg::BFIE_OP_IO_OUT, 5'h00, 5'h10, 3'h0, 8'h00, 8'h15, 8'h81},
    '{bfie_pkg::BFIE_OP_FLAG_DROP, 5'h00, 5'h00, 3'h0, 8'h00, 8'h14, 8'h00},
    '{bfie_pkg::BFIE_OP_LOAD_IMM, 5'h11, 5'h00, 3'h0, 8'h01, 8'h14, 8'h00},
    '{bfie_pkg::BFIE_OP_ROTATE_RIGHT_CARRY, 5'h11, 5'h00, 3'h0, 8'h00, 8'h1B, 8'h00},
    '{bfie_pkg::BFIE_OP_IO_OUT, 5'h00, 5'h11, 3'h0, 8'h00, 8'h1B, 8'h00},
    '{bfie_pkg::BFIE_OP_REG_BIT_TO_TFLAG, 5'h10, 5'h00, 3'h7, 8'h00, 8'h5B, 8'h00},
    '{bfie_pkg::BFIE_OP_TFLAG_TO_REG_BIT, 5'h11, 5'h00, 3'h4, 8'h00, 8'h5B, 8'h00},
    '{bfie_pkg::BFIE_OP_IO_OUT, 5'h00, 5'h11, 3'h0, 8'h00, 8'h5B, 8'h10},
    '{bfie_pkg::BFIE_OP_REG_BIT_TO_TFLAG, 5'h10, 5'h00, 3'h1, 8'h00, 8'h1B, 8'h00},
    '{bfie_pkg::BFIE_OP_TFLAG_TO_REG_BIT, 5'h10, 5'h00, 3'h0, 8'h00, 8'h1B, 8'h00},
    '{bfie_pkg::BFIE_OP_IO_OUT, 5'h00, 5'h10, 3'h0, 8'h00, 8'h1B, 8'h80},
    '{bfie_pkg::BFIE_OP_MOVE, 5'h12, 5'h11, 3'h0, 8'h00, 8'h1B, 8'h00},
    '{bfie_pkg::BFIE_OP_IO_OUT, 5'h00, 5'h12, 3'h0, 8'h00, 8'h1B, 8'h10},
    '{bfie_pkg::BFIE_OP_NIBBLE_SWAP, 5'h12, 5'h00, 3'h0, 8'h00, 8'h1B, 8'h00},
    '{bfie_pkg::BFIE_OP_IO_OUT, 5'h00, 5'h12, 3'h0, 8'h00, 8'h1B, 8'h01},
    '{bfie_pkg::BFIE_OP_SHIFT_LEFT, 5'h12, 5'h00, 3'h0, 8'h00, 8'h00, 8'h00},
    '{bfie_pkg::BFIE_OP_IO_OUT, 5'h00, 5'h12, 3'h0, 8'h00, 8'h00, 8'h02},
    '{bfie_pkg::BFIE_OP_SHIFT_RIGHT_SIGNED, 5'h10, 5'h00, 3'h0, 8'h00, 8'h0C, 8'h00},
    '{bfie_pkg::BFIE_OP_SHIFT_RIGHT, 5'h10, 5'h00, 3'h0, 8'h00, 8'h00, 8'h00},
    '{bfie_pkg::BFIE_OP_IO_OUT, 5'h00, 5'h10, 3'h0, 8'h00, 8'h00, 8'h60},
    '{bfie_pkg::BFIE_OP_NOP, 5'h00, 5'h00, 3'h0, 8'h00, 8'h00, 8'h00},
    '{bfie_pkg::BFIE_OP_LOAD_IMM, 5'h15, 5'h00, 3'h0, 8'h01, 8'h00, 8'h00},
    '{bfie_pkg::BFIE_OP_ROTATE_RIGHT_CARRY, 5'h15, 5'h00, 3'h0, 8'h00, 8'h1B, 8'h00}
  };
  // device under test
  bfie_exec bfie_exec_inst (.clk(clk), .resetn(resetn), .instrValid(instrValid),
    .instrOp(instrOp), .instrDst(instrDst), .instrSrc(instrSrc), .instrBit(instrBit),
    .instrImm(instrImm), .instrIo(instrIo), .instrReady(instrReady), .ioRd(ioRd),
    .ioRdAddr(ioRdAddr), .ioRdData(ioRdData), .ioWr(ioWr), .ioWrAddr(ioWrAddr),
    .ioWrData(ioWrData), .dataRd(dataRd), .dataWr(dataWr), .dataAddr(dataAddr),
    .dataWrData(dataWrData), .dataRdData(dataRdData), .progRd(progRd), .progAddr(progAddr),
    .progRdData(progRdData), .statusRegister(statusRegister), .sleepReq(sleepReq),
    .wdtKick(wdtKick));
  // peripheral and memory answers, inverted when not asked
  assign ioRdData = ioRd ? ioVal : ~ioVal;
  always @(posedge clk) begin
    dataRdData <= dataRd ? memVal : ~memVal;
    progRdData <= progRd ? progVal : ~progVal;
  end
  initial begin
    forever #2.5 clk = ~clk;
  end
  task automatic close_out();
    if (n_errors == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : close_out
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic do_reset(input int n);
    @(posedge clk);
    resetn <= 1'b0;
    repeat (n) @(posedge clk);
    resetn <= 1'b1;
    #1;
    chk({instrReady, ioRd, ioWr, dataRd, dataWr, progRd, sleepReq, wdtKick, statusRegister},
      {8'h80, 8'h00});
  endtask : do_reset
  // issue one op, snapshot exec cycle and the cycle after
  task automatic run(input bfie_pkg::bfie_op_t o, input logic [4:0] d, input logic [4:0] s,
      input logic [2:0] b, input logic [7:0] k, input logic [5:0] io);
    int n;
    n = 0;
    while (instrReady !== 1'b1 && n < 20) begin
      @(posedge clk);
      #1;
      n++;
    end
    @(posedge clk);
    instrValid <= 1'b1;
    instrOp <= o;
    instrDst <= d;
    instrSrc <= s;
    instrBit <= b;
    instrImm <= k;
    instrIo <= io;
    @(posedge clk);
    instrValid <= 1'b0;
    #1;
    {s1IoRd, s1IoAddr, s1Ready, s1Sleep, s1Kick} = {ioRd, ioRdAddr, instrReady, sleepReq, wdtKick};
    {s1DataRd, s1DataWr, s1DataAddr, s1DataWrData} = {dataRd, dataWr, dataAddr, dataWrData};
    {s1ProgRd, s1ProgAddr} = {progRd, progAddr};
    @(posedge clk);
    #1;
    {s2IoWr, s2IoAddr, s2IoData, s2Sr} = {ioWr, ioWrAddr, ioWrData, statusRegister};
    {s2Ready, s2Sleep, s2Kick} = {instrReady, sleepReq, wdtKick};
  endtask : run
  initial begin
    #20000;
    n_errors++;
    close_out();
  end
  initial begin
    do_reset(16);
    foreach (rows[i]) begin
      run(rows[i].op, rows[i].d, rows[i].s, rows[i].b, rows[i].k, 6'h2A);
      chk(s2Sr, rows[i].sr);
      chk(s2IoWr, rows[i].op == bfie_pkg::BFIE_OP_IO_OUT);
      if (rows[i].op == bfie_pkg::BFIE_OP_IO_OUT) begin
        chk({s2IoAddr, s2IoData}, {6'h2A, rows[i].out});
      end
    end
    ioVal <= 8'h5A;
    run(bfie_pkg::BFIE_OP_IO_BIT_SETTER, 5'h00, 5'h00, 3'h7, 8'h00, 6'h12);
    chk({s1IoRd, s1Ready, s1IoAddr, s2IoWr, s2Ready, s2IoAddr}, {2'b10, 6'h12, 2'b11, 6'h12});
    chk({s2IoData, s2Sr}, {8'hDA, 8'h1B});
    run(bfie_pkg::BFIE_OP_IO_BIT_CLEARER, 5'h00, 5'h00, 3'h1, 8'h00, 6'h21);
    chk({s1IoRd, s1Ready, s1IoAddr, s2IoWr, s2Ready, s2IoAddr}, {2'b10, 6'h21, 2'b11, 6'h21});
    chk({s2IoData, s2Sr}, {8'h58, 8'h1B});
    run(bfie_pkg::BFIE_OP_LOAD_IMM, 5'h1E, 5'h00, 3'h0, 8'h34, 6'h00);
    run(bfie_pkg::BFIE_OP_LOAD_IMM, 5'h1F, 5'h00, 3'h0, 8'h12, 6'h00);
    run(bfie_pkg::BFIE_OP_INDIRECT_WRITE, 5'h00, 5'h10, 3'h0, 8'h00, 6'h00);
    chk({s1DataWr, s1Ready, s2Ready, s1DataAddr, s1DataWrData}, {3'b101, 16'h1234, 8'h60});
    memVal <= 8'hA5;
    run(bfie_pkg::BFIE_OP_INDIRECT_FETCH, 5'h13, 5'h00, 3'h0, 8'h00, 6'h00);
    chk({s1DataRd, s1Ready, s2Ready, s1DataAddr, s2Sr}, {3'b101, 16'h1234, 8'h1B});
    run(bfie_pkg::BFIE_OP_IO_OUT, 5'h00, 5'h13, 3'h0, 8'h00, 6'h01);
    chk(s2IoData, 8'hA5);
    progVal <= 16'hC3E7;
    for (int i = 0; i < 2; i++) begin
      run(bfie_pkg::BFIE_OP_LOAD_IMM, 5'h1E, 5'h00, 3'h0, {7'h1A, i[0]}, 6'h00);
      run(bfie_pkg::BFIE_OP_PROGRAM_MEMORY_FETCH, 5'h00, 5'h00, 3'h0, 8'h00, 6'h00);
      chk({s1ProgRd, s1Ready, s2Ready, s1ProgAddr, s2Sr}, {3'b100, 15'h091A, 8'h1B});
      run(bfie_pkg::BFIE_OP_IO_OUT, 5'h00, 5'h00, 3'h0, 8'h00, 6'h01);
      chk(s2IoData, i[0] ? 8'hC3 : 8'hE7);
    end
    ioVal <= 8'h3C;
    run(bfie_pkg::BFIE_OP_IO_IN, 5'h14, 5'h00, 3'h0, 8'h00, 6'h07);
    chk({s1IoRd, s1IoAddr, s2Sr}, {1'b1, 6'h07, 8'h1B});
    run(bfie_pkg::BFIE_OP_IO_OUT, 5'h00, 5'h14, 3'h0, 8'h00, 6'h01);
    chk(s2IoData, 8'h3C);
    run(bfie_pkg::BFIE_OP_SLEEP, 5'h00, 5'h00, 3'h0, 8'h00, 6'h00);
    chk({s1Sleep, s1Kick, s2Sleep, s2Sr}, {3'b100, 8'h1B});
    run(bfie_pkg::BFIE_OP_WATCHDOG_KICK, 5'h00, 5'h00, 3'h0, 8'h00, 6'h00);
    chk({s1Kick, s1Sleep, s2Kick, s2Sr}, {3'b100, 8'h1B});
    expSr = 8'h1B;
    for (int b = 0; b < 8; b++) begin
      run(bfie_pkg::BFIE_OP_FLAG_RAISE, 5'h00, 5'h00, b[2:0], 8'h00, 6'h00);
      expSr[b] = 1'b1;
      chk(s2Sr, expSr);
    end
    for (int b = 0; b < 8; b++) begin
      run(bfie_pkg::BFIE_OP_FLAG_DROP, 5'h00, 5'h00, b[2:0], 8'h00, 6'h00);
      expSr[b] = 1'b0;
      chk(s2Sr, expSr);
    end
    run(bfie_pkg::BFIE_OP_FLAG_RAISE, 5'h00, 5'h00, 3'h3, 8'h00, 6'h00);
    do_reset(3);
    close_out();
  end
endmodule : bfie_exec_bench
`default_nettype wire
